/* dsp_cycle_sequencer.sv */
/*
  Machine-cycle sequencer: takes one decoded instruction, holds issue
  for its extra cycles, flags second-word fetch and pipeline refill.
  Assumes a decoder on the same clock presents cycle and word counts.
*/
`include "dsp_timing_params.svh"

module dsp_cycle_sequencer (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic wait_in,
  input wire logic valid_in,
  input wire logic [`CYC_W-1:0] cycles_in,
  input wire logic [`WRD_W-1:0] words_in,
  input wire logic redirect_in,
  output logic ready_out,
  output logic hold_out,
  output logic fetch2_out,
  output logic refill_out,
  output logic [`CYC_W-1:0] index_out,
  output logic [`CYC_W-1:0] total_out,
  output logic [`WRD_W-1:0] words_out
);

  dsp_timing_pkg::seq_state_t state_r;
  dsp_timing_pkg::seq_state_t state_nxt;
  logic [`CYC_W-1:0] idx_r;
  logic [`CYC_W-1:0] total_r;
  logic [`WRD_W-1:0] words_r;
  logic redirect_r;
  logic fetch2_r;
  logic refill_r;

  wire in_issue = (state_r == dsp_timing_pkg::ST_ISSUE);
  wire take = in_issue && valid_in && !wait_in;
  wire advance = !in_issue && !wait_in;
  wire [`CYC_W-1:0] idx_inc = idx_r + `CYC_ONE;
  wire multi = (cycles_in > `CYC_ONE);
  wire at_end = (idx_inc == total_r);
  wire two_word = (words_in == `WRD_TWO);
  // refill lands in the final machine cycle
  wire refill_take = redirect_in && (cycles_in == `CYC_TWO);
  wire refill_adv = redirect_r && (idx_inc == total_r - `CYC_ONE);

  // stretched cycles keep everything still
  assign ready_out = in_issue && !wait_in;
  assign hold_out = !in_issue;
  assign fetch2_out = fetch2_r;
  assign refill_out = refill_r;
  assign index_out = idx_r;
  assign total_out = total_r;
  assign words_out = words_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dsp_timing_pkg::ST_ISSUE: begin
        if (take && multi) begin
          state_nxt = dsp_timing_pkg::ST_EXTRA;
        end
      end
      dsp_timing_pkg::ST_EXTRA: begin
        if (advance && at_end) begin
          state_nxt = dsp_timing_pkg::ST_ISSUE;
        end
      end
      default: begin
        state_nxt = dsp_timing_pkg::ST_ISSUE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_r <= dsp_timing_pkg::ST_ISSUE;
      idx_r <= `CYC_ZERO;
      total_r <= `CYC_ZERO;
      words_r <= `WRD_ONE;
      redirect_r <= 1'b0;
      fetch2_r <= 1'b0;
      refill_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (take) begin
        idx_r <= `CYC_ONE;
        total_r <= cycles_in;
        words_r <= words_in;
        redirect_r <= redirect_in;
        fetch2_r <= two_word && multi;
        refill_r <= refill_take;
      end else if (advance) begin
        idx_r <= idx_inc;
        fetch2_r <= 1'b0;
        refill_r <= refill_adv && !at_end;
      end else if (in_issue) begin
        fetch2_r <= 1'b0;
        refill_r <= 1'b0;
      end
    end
  end

endmodule

/* dsp_instruction_timing_decode.sv */
/*
  Instruction timing decoder for a 16-bit fixed-point DSP core: maps a
  classified instruction to its machine-cycle and program-word counts
  and drives the cycle sequencer.
  Assumes the fetch logic on REF_CLK_IN presents the instruction class,
  operand form and condition result; no opcode decoding is done here.
*/
// Summary of operation
// - most instructions one cycle; long operand adds exactly one
// - long-operand alu, multiply, push, field test forms take two words
// - immediate add/sub/compare to target: two cycles, two words
// - conditional jump/call/returns: two cycles, three if condition met
// - relative jump and call: two cycles, one word, either outcome
// - call via accumulator: three cycles, one word
// - program-to-data move three cycles, data-to-program four; one word
// - field set/clear/toggle 2c2w; field tests 1c or 2c; bit test 1c
// - block loop 2c2w; single loop and loop break 1c1w
// - context swap, int enable/disable, delayed returns 1c; trap 2c
// - return with stack adjust: three cycles, one word
// - push register 1c1w, push long immediate 2c2w, pop 1c1w
// - multiply variants 1c or 2c long; short, square forms 1c
// - conditional accumulator modifications take one cycle, one word
// - left justify step 2c1w; division step, max, min and kin 1c
// - shift moves, round move, swap, bank exchange: one cycle, one word
// - page load and field load: one cycle, one word
// - fast fetch sync option adds one cycle to pipeline-breaking flow other than trap
// - machine cycle is one clock, stretched while wait is asserted
// - fast option: accumulator-addressed flow after accum write +1 cycle
`include "dsp_timing_params.svh"

module dsp_instruction_timing_decode (
  input wire logic REF_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic INSTR_VALID_IN,
  input wire logic [`CLASS_W-1:0] INSTR_CLASS_IN,
  input wire logic LONG_OPERAND_IN,
  input wire logic COND_MET_IN,
  input wire logic PC_DEST_IN,
  input wire logic ACC_ADDR_DEP_IN,
  input wire logic FAST_SYNC_IN,
  input wire logic WAIT_IN,
  output logic INSTR_READY_OUT,
  output logic PC_HOLD_OUT,
  output logic FETCH_WORD2_OUT,
  output logic REFILL_OUT,
  output logic [`CYC_W-1:0] CYCLE_INDEX_OUT,
  output logic [`CYC_W-1:0] CYCLE_TOTAL_OUT,
  output logic [`WRD_W-1:0] WORD_COUNT_OUT
);

  dsp_timing_pkg::instr_class_t iclass;
  logic [`CYC_W-1:0] base_cyc;
  logic [`WRD_W-1:0] base_wrd;
  logic long_ok;
  logic cond_form;
  logic redirect_base;
  logic fast_group;
  logic acc_addr;

  assign iclass = dsp_timing_pkg::instr_class_t'(INSTR_CLASS_IN);

  // base timing per class
  always_comb begin
    base_cyc = `CYC_ONE;
    base_wrd = `WRD_ONE;
    long_ok = 1'b0;
    cond_form = 1'b0;
    redirect_base = 1'b0;
    fast_group = 1'b0;
    acc_addr = 1'b0;
    case (iclass)
      dsp_timing_pkg::ALU_LONGABLE: begin
        long_ok = 1'b1;
      end
      dsp_timing_pkg::ALU_SIMPLE: begin
        base_cyc = `CYC_ONE;
      end
      dsp_timing_pkg::ALU_IMM_TARGET: begin
        base_cyc = `CYC_TWO;
        base_wrd = `WRD_TWO;
      end
      dsp_timing_pkg::ACCUM_MODIFY: begin
        base_cyc = `CYC_ONE;
      end
      dsp_timing_pkg::LEFT_JUSTIFY: begin
        base_cyc = `CYC_TWO;
      end
      dsp_timing_pkg::ALU_ONE_CYCLE: begin
        base_cyc = `CYC_ONE;
      end
      dsp_timing_pkg::MULT_LONGABLE: begin
        long_ok = 1'b1;
      end
      dsp_timing_pkg::MULT_SHORT: begin
        base_cyc = `CYC_ONE;
      end
      dsp_timing_pkg::BITFIELD_MOD: begin
        base_cyc = `CYC_TWO;
        base_wrd = `WRD_TWO;
      end
      dsp_timing_pkg::BITFIELD_TEST: begin
        long_ok = 1'b1;
      end
      dsp_timing_pkg::SINGLE_BIT_TEST: begin
        base_cyc = `CYC_ONE;
      end
      dsp_timing_pkg::SHIFT_MOVE: begin
        base_cyc = `CYC_ONE;
      end
      dsp_timing_pkg::MOVE_DATA: begin
        long_ok = 1'b1;
        fast_group = PC_DEST_IN;
        redirect_base = PC_DEST_IN;
        acc_addr = PC_DEST_IN;
      end
      dsp_timing_pkg::PROG_TO_DATA: begin
        base_cyc = `CYC_THREE;
        acc_addr = 1'b1;
      end
      dsp_timing_pkg::DATA_TO_PROG: begin
        base_cyc = `CYC_FOUR;
      end
      dsp_timing_pkg::PUSH_STACK: begin
        long_ok = 1'b1;
      end
      dsp_timing_pkg::POP_STACK: begin
        base_cyc = `CYC_ONE;
        fast_group = PC_DEST_IN;
        redirect_base = PC_DEST_IN;
      end
      dsp_timing_pkg::LOOP_SINGLE: begin
        base_cyc = `CYC_ONE;
        fast_group = 1'b1;
        acc_addr = 1'b1;
      end
      dsp_timing_pkg::LOOP_BLOCK: begin
        base_cyc = `CYC_TWO;
        base_wrd = `WRD_TWO;
      end
      dsp_timing_pkg::LOOP_BREAK: begin
        base_cyc = `CYC_ONE;
      end
      dsp_timing_pkg::JUMP_COND,
      dsp_timing_pkg::CALL_COND: begin
        base_cyc = `CYC_TWO;
        base_wrd = `WRD_TWO;
        cond_form = 1'b1;
        redirect_base = COND_MET_IN;
        fast_group = COND_MET_IN;
      end
      dsp_timing_pkg::RET_COND,
      dsp_timing_pkg::RETI_COND: begin
        base_cyc = `CYC_TWO;
        cond_form = 1'b1;
        redirect_base = COND_MET_IN;
        fast_group = COND_MET_IN;
      end
      dsp_timing_pkg::JUMP_REL,
      dsp_timing_pkg::CALL_REL: begin
        base_cyc = `CYC_TWO;
        redirect_base = COND_MET_IN;
        fast_group = COND_MET_IN;
      end
      dsp_timing_pkg::CALL_ACCUM: begin
        base_cyc = `CYC_THREE;
        redirect_base = 1'b1;
        fast_group = 1'b1;
        acc_addr = 1'b1;
      end
      dsp_timing_pkg::RET_DELAYED,
      dsp_timing_pkg::RETI_DELAYED: begin
        base_cyc = `CYC_ONE;
        fast_group = 1'b1;
      end
      dsp_timing_pkg::STACK_ADJ_RET: begin
        base_cyc = `CYC_THREE;
        redirect_base = 1'b1;
        fast_group = 1'b1;
      end
      dsp_timing_pkg::SW_INTERRUPT: begin
        base_cyc = `CYC_TWO;
        redirect_base = 1'b1;
      end
      dsp_timing_pkg::CONTROL_ONE: begin
        base_cyc = `CYC_ONE;
      end
      dsp_timing_pkg::PAGE_LOAD: begin
        base_cyc = `CYC_ONE;
      end
      default: begin
        base_cyc = `CYC_ONE;
      end
    endcase
  end

  // extra cycle only when its condition applies
  function automatic logic [`CYC_W-1:0] extra_if(
    input logic en,
    input logic [`CYC_W-1:0] amt
  );
    return en ? amt : `CYC_ZERO;
  endfunction

  // extra cycles and words on top of the class base
  wire use_long = long_ok && LONG_OPERAND_IN;
  wire [`CYC_W-1:0] long_add = extra_if(use_long, `EXTRA_LONG);
  wire [`WRD_W-1:0] word_sel = use_long ? `WRD_TWO : base_wrd;
  wire [`CYC_W-1:0] cond_add =
    extra_if(cond_form && COND_MET_IN, `EXTRA_COND);
  wire [`CYC_W-1:0] fast_add =
    extra_if(FAST_SYNC_IN && fast_group, `EXTRA_FAST);
  wire [`CYC_W-1:0] dep_add =
    extra_if(FAST_SYNC_IN && acc_addr && ACC_ADDR_DEP_IN,
    `EXTRA_DEP);
  wire [`CYC_W-1:0] cyc_sel = base_cyc + long_add + cond_add + fast_add
    + dep_add;
  // a redirect needs a spare cycle to refill
  wire redirect_sel = redirect_base && (cyc_sel > `CYC_ONE);

  dsp_cycle_sequencer seq_u (
    .clk_in(REF_CLK_IN),
    .resetn_in(RESETN_IN),
    .wait_in(WAIT_IN),
    .valid_in(INSTR_VALID_IN),
    .cycles_in(cyc_sel),
    .words_in(word_sel),
    .redirect_in(redirect_sel),
    .ready_out(INSTR_READY_OUT),
    .hold_out(PC_HOLD_OUT),
    .fetch2_out(FETCH_WORD2_OUT),
    .refill_out(REFILL_OUT),
    .index_out(CYCLE_INDEX_OUT),
    .total_out(CYCLE_TOTAL_OUT),
    .words_out(WORD_COUNT_OUT)
  );

endmodule

/* dsp_timing_params.svh */
/*
  Timing constants for the instruction timing decoder: cycle and word
  counts per instruction class and the extra-cycle increments.
  Assumes it is included by bare name before any module that uses it.
*/
`ifndef DSP_TIMING_PARAMS_SVH
`define DSP_TIMING_PARAMS_SVH

`define CYC_W 3
`define CYC_ZERO 3'h0
`define CYC_ONE 3'h1
`define CYC_TWO 3'h2
`define CYC_THREE 3'h3
`define CYC_FOUR 3'h4
`define EXTRA_LONG 3'h1
`define EXTRA_COND 3'h1
`define EXTRA_FAST 3'h1
`define EXTRA_DEP 3'h1

`define WRD_W 2
`define WRD_ONE 2'h1
`define WRD_TWO 2'h2

`define CLASS_W 6

`endif

/* dsp_timing_pkg.sv */
/*
  Types shared by the instruction timing decoder and its sequencer.
  Assumes dsp_timing_params.svh is available for widths.
*/
`include "dsp_timing_params.svh"

package dsp_timing_pkg;

  typedef enum logic [`CLASS_W-1:0] {
    ALU_LONGABLE    = 6'b000000,
    ALU_SIMPLE      = 6'b000001,
    ALU_IMM_TARGET  = 6'b000010,
    ACCUM_MODIFY    = 6'b000011,
    LEFT_JUSTIFY    = 6'b000100,
    ALU_ONE_CYCLE   = 6'b000101,
    MULT_LONGABLE   = 6'b000110,
    MULT_SHORT      = 6'b000111,
    BITFIELD_MOD    = 6'b001000,
    BITFIELD_TEST   = 6'b001001,
    SINGLE_BIT_TEST = 6'b001010,
    SHIFT_MOVE      = 6'b001011,
    MOVE_DATA       = 6'b001100,
    PROG_TO_DATA    = 6'b001101,
    DATA_TO_PROG    = 6'b001110,
    PUSH_STACK      = 6'b001111,
    POP_STACK       = 6'b010000,
    LOOP_SINGLE     = 6'b010001,
    LOOP_BLOCK      = 6'b010010,
    LOOP_BREAK      = 6'b010011,
    JUMP_COND       = 6'b010100,
    CALL_COND       = 6'b010101,
    RET_COND        = 6'b010110,
    RETI_COND       = 6'b010111,
    JUMP_REL        = 6'b011000,
    CALL_REL        = 6'b011001,
    CALL_ACCUM      = 6'b011010,
    RET_DELAYED     = 6'b011011,
    RETI_DELAYED    = 6'b011100,
    STACK_ADJ_RET   = 6'b011101,
    SW_INTERRUPT    = 6'b011110,
    CONTROL_ONE     = 6'b011111,
    PAGE_LOAD       = 6'b100000
  } instr_class_t;

  typedef enum logic [1:0] {
    ST_ISSUE = 2'b00,
    ST_EXTRA = 2'b01
  } seq_state_t;

endpackage

/* prog_mem_model.sv */
/*
  program memory model: stretches fetch cycles with random waits.
  assumes the bench clock; slow_in enables the stretching.
*/
module prog_mem_model (
  input wire logic clk_in,
  input wire logic slow_in,
  output logic wait_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // new wait level at each falling edge
  always @(negedge clk_in) begin
    wait_out <= slow_in && ($urandom_range(3) == 0);
  end
endmodule

/* tb_top.sv */
/*
  self-checking bench for the timing decoder: integer model per class.
  assumes one clock; waits come from the program memory model.
*/
`include "dsp_timing_params.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s exp %0d got %0d", nm, e, g); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, valid, long_op, cond, pcd, dep, fast, wt, slow;
  logic [`CLASS_W-1:0] cls;
  logic ready, hold, f2, refill;
  logic [`CYC_W-1:0] idx, tot;
  logic [`WRD_W-1:0] wrd;
  int n_fail = 0;
  int checks = 0;
  int cyc_cnt = 0;
  int c;
  // per-class base counts
  int base_c[33] = '{1, 1, 2, 1, 2, 1, 1, 1, 2, 1, 1, 1, 1, 3, 4, 1, 1,
    1, 2, 1, 2, 2, 2, 2, 2, 2, 3, 1, 1, 3, 2, 1, 1};
  // words per class
  int base_w[33] = '{1, 1, 2, 1, 1, 1, 1, 1, 2, 1, 1, 1, 1, 1, 1, 1, 1,
    1, 2, 1, 2, 2, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1};

  dsp_instruction_timing_decode uut (.REF_CLK_IN(clk), .RESETN_IN(rstn),
    .INSTR_VALID_IN(valid), .INSTR_CLASS_IN(cls),
    .LONG_OPERAND_IN(long_op), .COND_MET_IN(cond), .PC_DEST_IN(pcd),
    .ACC_ADDR_DEP_IN(dep), .FAST_SYNC_IN(fast), .WAIT_IN(wt),
    .INSTR_READY_OUT(ready), .PC_HOLD_OUT(hold), .FETCH_WORD2_OUT(f2),
    .REFILL_OUT(refill), .CYCLE_INDEX_OUT(idx), .CYCLE_TOTAL_OUT(tot),
    .WORD_COUNT_OUT(wrd));
  prog_mem_model mem (.clk_in(clk), .slow_in(slow), .wait_out(wt));

  function automatic bit longable(int k);
    return k inside {0, 6, 9, 12, 15};
  endfunction

  function automatic int exp_cyc(int k, bit l, bit m, bit f, bit d, bit p);
    int n;
    n = base_c[k] + ((longable(k) && l) ? 1 : 0);
    if (k inside {[20:23]} && m) n++;
    if (f && ((k inside {[20:25]} && m) || (k inside {12, 16} && p)
        || k inside {17, 26, 27, 28, 29})) n++;
    if (f && d && ((k == 12 && p) || k inside {13, 17, 26})) n++;
    return n;
  endfunction

  function automatic bit exp_redir(int k, bit m, bit p);
    return (k inside {[20:25]} && m) || (k inside {12, 16} && p)
      || k inside {26, 29, 30};
  endfunction

  function automatic bit coin();
    return 1'($urandom_range(1));
  endfunction

  task automatic tally_and_finish();
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic run_one(int k, bit l, bit m, bit f, bit d, bit p);
    int n, w, g, t, r, ri, er;
    n = exp_cyc(k, l, m, f, d, p);
    w = base_w[k] + ((longable(k) && l) ? 1 : 0);
    er = (exp_redir(k, m, p) && n > 1) ? 1 : 0;
    cls = k[5:0];
    long_op = l && longable(k);
    cond = m;
    fast = f;
    dep = d;
    pcd = p;
    valid = 1'b1;
    forever begin
      #1;
      if (ready === 1'b1) break;
      @(negedge clk);
    end
    @(negedge clk);
    valid = 1'b0;
    #1;
    `CHK("total", n, tot)
    `CHK("words", w, wrd)
    `CHK("index", 1, idx)
    `CHK("fetch2", (w == 2), f2)
    g = 0;
    t = 0;
    r = 0;
    ri = 0;
    while (hold === 1'b1 && t < 60) begin
      if (wt === 1'b0) g++;
      if (wt === 1'b0 && refill === 1'b1) begin
        r++;
        ri = idx;
      end
      t++;
      @(negedge clk);
      #1;
    end
    `CHK("extra", n - 1, g)
    `CHK("refill", er, r)
    if (er == 1) `CHK("refill_at", n - 1, ri)
    `CHK("refill_end", 0, refill)
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    forever begin
      @(posedge clk);
      cyc_cnt++;
      if (cyc_cnt > 20000) begin
        n_fail++;
        tally_and_finish();
      end
    end
  end

  initial begin
    void'($urandom(47));
    {rstn, valid, long_op, cond, pcd, dep, fast, slow} = '0;
    cls = '0;
    repeat (4) @(negedge clk);
    #1;
    `CHK("rst_total", 0, tot)
    `CHK("rst_words", 1, wrd)
    `CHK("rst_hold", 0, hold)
    rstn = 1'b1;
    for (int k = 0; k < 33; k++) begin
      for (int j = 0; j < 4; j++) begin
        run_one(k, j[0], j[1], 1'b0, 1'b0, 1'b0);
      end
    end
    for (int k = 0; k < 33; k++) begin
      for (int j = 0; j < 16; j++) begin
        run_one(k, j[0], j[1], 1'b1, j[2], j[3]);
      end
    end
    slow = 1'b1;
    repeat (300) begin
      c = $urandom_range(32);
      run_one(c, coin(), coin(), coin(), coin(), coin());
    end
    run_one(20, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    run_one(20, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    run_one(24, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    run_one(26, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    tally_and_finish();
  end
endmodule

/* timing_monitor.sv */
/*
  port assertions for the timing decoder: issue, hold, counts, refill.
  assumes it is bound to the decoder top on its single clock.
*/
`include "dsp_timing_params.svh"

module timing_monitor (
  input wire logic REF_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic INSTR_VALID_IN,
  input wire logic [`CLASS_W-1:0] INSTR_CLASS_IN,
  input wire logic COND_MET_IN,
  input wire logic FAST_SYNC_IN,
  input wire logic WAIT_IN,
  input wire logic INSTR_READY_OUT,
  input wire logic PC_HOLD_OUT,
  input wire logic REFILL_OUT,
  input wire logic [`CYC_W-1:0] CYCLE_INDEX_OUT,
  input wire logic [`CYC_W-1:0] CYCLE_TOTAL_OUT,
  input wire logic [`WRD_W-1:0] WORD_COUNT_OUT
);
  logic take;
  logic [3:0] nxt_idx;
  logic [3:0] tot;
  assign take = INSTR_VALID_IN && INSTR_READY_OUT;
  assign nxt_idx = {1'b0, CYCLE_INDEX_OUT} + 4'h1;
  assign tot = {1'b0, CYCLE_TOTAL_OUT};
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  a_hold_blocks_issue: assert property (
    PC_HOLD_OUT |-> !INSTR_READY_OUT) else $error("issue while held");
  a_wait_blocks_issue: assert property (
    WAIT_IN |-> !INSTR_READY_OUT) else $error("issue during wait");
  a_wait_freezes_seq: assert property (
    PC_HOLD_OUT && WAIT_IN |=> PC_HOLD_OUT && $stable(CYCLE_INDEX_OUT))
    else $error("wait did not freeze");
  a_first_index: assert property (
    take |=> CYCLE_INDEX_OUT == 3'h1) else $error("first index wrong");
  a_index_steps: assert property (
    PC_HOLD_OUT && !WAIT_IN && nxt_idx < tot
    |=> CYCLE_INDEX_OUT == $past(CYCLE_INDEX_OUT) + 3'h1)
    else $error("index did not step");
  a_hold_release: assert property (
    PC_HOLD_OUT && !WAIT_IN && nxt_idx == tot
    |=> !PC_HOLD_OUT && INSTR_READY_OUT == !WAIT_IN)
    else $error("hold not released");
  a_counts_stand: assert property (
    !take |=> $stable(CYCLE_TOTAL_OUT) && $stable(WORD_COUNT_OUT))
    else $error("counts changed without take");
  a_jump_counts: assert property (
    take && INSTR_CLASS_IN == dsp_timing_pkg::JUMP_COND && !FAST_SYNC_IN
    |=> WORD_COUNT_OUT == 2'h2
    && CYCLE_TOTAL_OUT == ($past(COND_MET_IN) ? 3'h3 : 3'h2))
    else $error("jump counts wrong");
  a_refill_in_extra: assert property (
    REFILL_OUT |-> PC_HOLD_OUT) else $error("refill outside extra");
  c_wait_hold: cover property (PC_HOLD_OUT && WAIT_IN);
  c_refill: cover property (REFILL_OUT);
  c_four: cover property (take ##1 CYCLE_TOTAL_OUT == 3'h4);
endmodule

bind dsp_instruction_timing_decode timing_monitor u_mon (.REF_CLK_IN,
  .RESETN_IN, .INSTR_VALID_IN, .INSTR_CLASS_IN, .COND_MET_IN,
  .FAST_SYNC_IN, .WAIT_IN, .INSTR_READY_OUT, .PC_HOLD_OUT, .REFILL_OUT,
  .CYCLE_INDEX_OUT, .CYCLE_TOTAL_OUT, .WORD_COUNT_OUT);
